// [ism_defines.svh]
// Constants for the identification, scratchpad and energy meter block.
// Assumes inclusion by bare name from the package, the block module and the bench.
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH

// Command codes on the management link
`define ISM_CMD_TOOL_A    8'hB0
`define ISM_CMD_TOOL_B    8'hB1
`define ISM_CMD_OEM       8'hB2
`define ISM_CMD_PSCRATCH  8'hB3
`define ISM_CMD_GSCRATCH  8'hB4
`define ISM_CMD_MAKER_A   8'hB5
`define ISM_CMD_INFO      8'hB6
`define ISM_CMD_MAKER_B   8'hBC
`define ISM_CMD_REV       8'h98
`define ISM_CMD_IDENT     8'hE7
`define ISM_CMD_LOT       8'hC2
`define ISM_CMD_RESTORE   8'h16
`define ISM_CMD_EIN_BASE  8'hD0
`define ISM_CMD_GAIN      8'hD8
`define ISM_CMD_TEMPCO    8'hD9
`define ISM_CMD_RANGE     8'hDA
`define ISM_CMD_PWR       8'hDB
`define ISM_CMD_CUR       8'hDC

// Field layout and reset values
`define ISM_EIN_WORDS     3'h6
`define ISM_INFO_ECC_BIT  5
`define ISM_WORD_RST      16'h0000
`define ISM_GAIN_RST      16'h0001

// Sense ranges in microvolts, full scale
`define ISM_FS_HIGH_UV    18'sh186A0
`define ISM_FS_MED_UV     18'sh0C350
`define ISM_FS_LOW_UV     18'sh04E20

// Scaling and time base
`define ISM_PPM_SCALE     48'h0000000F4240
`define ISM_TC_REF_C      9'sh019
`define ISM_MILLI         48'h0000000003E8
`define ISM_CLK_HZ        20000000
`define ISM_TB_PERIOD_MS  1

`endif

// [ism_pkg.sv]
// Types shared by the identification, scratchpad and energy meter block.
// Assumes the constants header is on the include path.
`include "ism_defines.svh"

package ism_pkg;

  // One command from the management link
  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [1:0]  page;
    logic [15:0] wdata;
  } ism_req_type;

  // One converter sample
  typedef struct packed {
    logic [15:0]        vin_mv;
    logic signed [17:0] sense_uv;
    logic signed [7:0]  temp_c;
  } ism_adc_type;

  // Current sense amplifier range
  typedef enum logic [1:0] {
    ISM_RNG_HIGH = 2'h0,
    ISM_RNG_MED  = 2'h1,
    ISM_RNG_LOW  = 2'h2
  } ism_range_type;

endpackage

// [ism_meter_regs.sv]
// Identification, user scratchpad and input energy meter register block.
// Assumes a link-side command engine on lnk_clk and converter samples on clk.
`timescale 1ns/1ps
`default_nettype none
`include "ism_defines.svh"

module ism_meter_regs
  import ism_pkg::*;
#(
  parameter int          PAGES      = 4,
  parameter int          TB_CYCLES  = `ISM_CLK_HZ / 1000 * `ISM_TB_PERIOD_MS,
  parameter logic [7:0]  REV_CODE   = 8'h5A,   // Arbitrary value
  parameter logic [15:0] IDENT_WORD = 16'hA5C3 // Arbitrary value
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          lnk_clk,
  input  wire logic          lnk_req_valid,
  input  wire ism_req_type   lnk_req,
  output logic               lnk_busy_ff,
  output logic               lnk_rsp_valid_ff,
  output logic [15:0]        lnk_rsp_data_ff,
  input  wire logic          adc_valid,
  input  wire ism_adc_type   adc_sample,
  input  wire logic          nvm_bulk_done,
  input  wire logic          nvm_ecc_ok,
  input  wire logic [31:0]   nvm_lot,
  output ism_range_type      sense_range_ff
);

  initial begin
    if (PAGES < 1 || PAGES > 4 || TB_CYCLES < 2) begin
      $error("ism_meter_regs: unsupported PAGES or TB_CYCLES");
    end
  end

  // Unsigned restoring divide
  function automatic logic [47:0] ism_udiv(input logic [47:0] n, input logic [47:0] d);
    logic [47:0] q;
    logic [48:0] r;
    q = 48'h0;
    r = 49'h0;
    for (int i = 47; i >= 0; i--) begin
      r = {r[47:0], n[i]};
      if (r >= {1'b0, d}) begin
        r = r - {1'b0, d};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  // Saturate to a signed word
  function automatic logic [15:0] ism_sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) return 16'h7FFF;
    if (v < -48'sh8000) return 16'h8000;
    return v[15:0];
  endfunction

  // Full scale of a sense range
  function automatic logic signed [17:0] ism_fs(input ism_range_type r);
    case (r)
      ISM_RNG_MED: return `ISM_FS_MED_UV;
      ISM_RNG_LOW: return `ISM_FS_LOW_UV;
      default:     return `ISM_FS_HIGH_UV;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: capture request, toggle handshake

  ism_req_type hold_ff;
  logic        req_tgl_ff;
  logic        ack_tgl_ff;
  logic        ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic [15:0] rsp_word_ff;
  logic        accept;
  logic        ack_edge;

  assign accept   = lnk_req_valid && !lnk_busy_ff;
  assign ack_edge = ack_s2_ff ^ ack_s3_ff;

  // Hold request stable until answered
  always_ff @(posedge lnk_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_ff    <= '0;
      req_tgl_ff <= 1'b0;
    end else if (accept) begin
      hold_ff    <= lnk_req;
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  // Acknowledge synchroniser
  always_ff @(posedge lnk_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
    end
  end

  // Busy flag and answer pulse
  always_ff @(posedge lnk_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk_busy_ff      <= 1'b0;
      lnk_rsp_valid_ff <= 1'b0;
      lnk_rsp_data_ff  <= `ISM_WORD_RST;
    end else begin
      lnk_rsp_valid_ff <= ack_edge;
      if (accept) lnk_busy_ff <= 1'b1;
      else if (ack_edge) lnk_busy_ff <= 1'b0;
      if (ack_edge) lnk_rsp_data_ff <= rsp_word_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: command execution

  logic        req_s1_ff, req_s2_ff, req_s3_ff;
  logic        go;
  logic        wr_go;
  logic [1:0]  pg;
  logic        pg_ok;
  logic [2:0]  ein_idx;
  logic        ein_hit;
  logic [15:0] rd_word;

  assign go      = req_s2_ff ^ req_s3_ff;
  assign wr_go   = go && hold_ff.wr;
  assign pg      = hold_ff.page;
  assign pg_ok   = 32'(pg) < PAGES;
  assign ein_idx = 3'(hold_ff.code - `ISM_CMD_EIN_BASE);
  assign ein_hit = hold_ff.code >= `ISM_CMD_EIN_BASE &&
                   hold_ff.code < `ISM_CMD_EIN_BASE + 8'(`ISM_EIN_WORDS);

  // Request synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  logic [15:0]   tool_a_ff, oem_ff, glob_ff;
  logic [15:0]   tool_b_ff [PAGES];
  logic [15:0]   pscr_ff   [PAGES];
  logic [15:0]   maker_a_ff[PAGES];
  logic [15:0]   maker_b_ff[PAGES];
  logic [7:0]    lot_ff    [PAGES];
  logic [15:0]   info_ff;
  logic          boot_ff;
  logic          refresh;
  logic [15:0]   gain_ff;
  logic [15:0]   tc_ff;
  logic [47:0]   energy_ff, etime_ff;
  logic [95:0]   snap_ff;
  logic signed [31:0] cur_ff;
  logic signed [47:0] pwr_ff;

  // Unpaged read/write words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tool_a_ff <= `ISM_WORD_RST;
      oem_ff    <= `ISM_WORD_RST;
      glob_ff   <= `ISM_WORD_RST;
    end else if (wr_go) begin
      if (hold_ff.code == `ISM_CMD_TOOL_A) tool_a_ff <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_OEM) oem_ff <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_GSCRATCH) glob_ff <= hold_ff.wdata;
    end
  end

  // Paged read/write words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PAGES; i++) begin
        tool_b_ff[i]  <= `ISM_WORD_RST;
        pscr_ff[i]    <= `ISM_WORD_RST;
        maker_a_ff[i] <= `ISM_WORD_RST;
        maker_b_ff[i] <= `ISM_WORD_RST;
      end
    end else if (wr_go && pg_ok) begin
      if (hold_ff.code == `ISM_CMD_TOOL_B) tool_b_ff[pg] <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_PSCRATCH) pscr_ff[pg] <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_MAKER_A) maker_a_ff[pg] <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_MAKER_B) maker_b_ff[pg] <= hold_ff.wdata;
    end
  end

  // Gain, coefficient and range settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gain_ff        <= `ISM_GAIN_RST;
      tc_ff          <= `ISM_WORD_RST;
      sense_range_ff <= ISM_RNG_HIGH;
    end else if (wr_go) begin
      if (hold_ff.code == `ISM_CMD_GAIN) gain_ff <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_TEMPCO) tc_ff <= hold_ff.wdata;
      if (hold_ff.code == `ISM_CMD_RANGE && hold_ff.wdata[1:0] != 2'h3) begin
        sense_range_ff <= ism_range_type'(hold_ff.wdata[1:0]);
      end
    end
  end

  // Refresh of stored information after boot, restore or bulk read
  assign refresh = boot_ff || nvm_bulk_done ||
                   (wr_go && hold_ff.code == `ISM_CMD_RESTORE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_ff <= 1'b1;
      info_ff <= `ISM_WORD_RST;
      for (int i = 0; i < PAGES; i++) lot_ff[i] <= 8'h00;
    end else begin
      boot_ff <= 1'b0;
      if (refresh) begin
        info_ff <= `ISM_WORD_RST;
        info_ff[`ISM_INFO_ECC_BIT] <= nvm_ecc_ok;
        for (int i = 0; i < PAGES; i++) lot_ff[i] <= nvm_lot[8*i +: 8];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_word = `ISM_WORD_RST;
    case (hold_ff.code)
      `ISM_CMD_TOOL_A:   rd_word = tool_a_ff;
      `ISM_CMD_OEM:      rd_word = oem_ff;
      `ISM_CMD_GSCRATCH: rd_word = glob_ff;
      `ISM_CMD_TOOL_B:   rd_word = pg_ok ? tool_b_ff[pg] : `ISM_WORD_RST;
      `ISM_CMD_PSCRATCH: rd_word = pg_ok ? pscr_ff[pg] : `ISM_WORD_RST;
      `ISM_CMD_MAKER_A:  rd_word = pg_ok ? maker_a_ff[pg] : `ISM_WORD_RST;
      `ISM_CMD_MAKER_B:  rd_word = pg_ok ? maker_b_ff[pg] : `ISM_WORD_RST;
      `ISM_CMD_REV:      rd_word = {8'h00, REV_CODE};
      `ISM_CMD_IDENT:    rd_word = IDENT_WORD;
      `ISM_CMD_LOT:      rd_word = pg_ok ? {8'h00, lot_ff[pg]} : `ISM_WORD_RST;
      `ISM_CMD_INFO:     rd_word = info_ff;
      `ISM_CMD_GAIN:     rd_word = gain_ff;
      `ISM_CMD_TEMPCO:   rd_word = tc_ff;
      `ISM_CMD_RANGE:    rd_word = {14'h0000, sense_range_ff};
      `ISM_CMD_PWR:      rd_word = ism_sat16(pwr_ff);
      `ISM_CMD_CUR:      rd_word = ism_sat16(48'(cur_ff));
      default: begin
        if (ein_hit) begin
          rd_word = (ein_idx == 3'h0) ? energy_ff[15:0] : snap_ff[16*ein_idx +: 16];
        end
      end
    endcase
  end

  // Answer word, acknowledge toggle and energy snapshot
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_word_ff <= `ISM_WORD_RST;
      ack_tgl_ff  <= 1'b0;
      snap_ff     <= '0;
    end else if (go) begin
      rsp_word_ff <= hold_ff.wr ? `ISM_WORD_RST : rd_word;
      ack_tgl_ff  <= ~ack_tgl_ff;
      if (!hold_ff.wr && ein_hit && ein_idx == 3'h0) snap_ff <= {etime_ff, energy_ff};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Telemetry: current, power, energy

  logic signed [17:0] clip_uv;
  logic signed [17:0] fs_uv;
  logic signed [25:0] tc_term;
  logic signed [26:0] tc_scale;
  logic [47:0]        num, den, cur_q, pwr_q;
  logic               pwr_go_ff;
  logic [15:0]        vin_ff;

  // Clip sense to the selected range
  always_comb begin
    fs_uv   = ism_fs(sense_range_ff);
    clip_uv = adc_sample.sense_uv;
    if (clip_uv > fs_uv) clip_uv = fs_uv;
    if (clip_uv < -fs_uv) clip_uv = -fs_uv;
  end

  // Tempco-compensated gain divisor
  always_comb begin
    tc_term  = 26'($signed(tc_ff) * (9'(adc_sample.temp_c) - `ISM_TC_REF_C));
    tc_scale = 27'($signed(`ISM_PPM_SCALE)) + 27'(tc_term);
    if (tc_scale < 27'sh1) tc_scale = 27'sh1;
    den = 48'(gain_ff) * 48'(tc_scale);
    if (den == 48'h0) den = 48'h1;
    num = 48'(clip_uv < 0 ? -clip_uv : clip_uv) * `ISM_PPM_SCALE;
    cur_q = ism_udiv(num, den);
    pwr_q = ism_udiv(48'(vin_ff) * 48'(cur_ff < 0 ? -cur_ff : cur_ff), `ISM_MILLI);
  end

  // Current and voltage capture per sample
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff    <= '0;
      vin_ff    <= `ISM_WORD_RST;
      pwr_go_ff <= 1'b0;
    end else begin
      pwr_go_ff <= adc_valid;
      if (adc_valid) begin
        vin_ff <= adc_sample.vin_mv;
        cur_ff <= (clip_uv < 0) ? -$signed(32'(cur_q[30:0])) : $signed(32'(cur_q[30:0]));
      end
    end
  end

  // Signed power in milliwatts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_ff <= '0;
    end else if (pwr_go_ff) begin
      pwr_ff <= (cur_ff < 0) ? -$signed(pwr_q) : $signed(pwr_q);
    end
  end

  // Millisecond time base
  logic [31:0] tb_cnt_ff;
  logic        tick_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_cnt_ff <= '0;
      tick_ff   <= 1'b0;
    end else begin
      tick_ff   <= (tb_cnt_ff == 32'(TB_CYCLES - 1));
      tb_cnt_ff <= (tb_cnt_ff == 32'(TB_CYCLES - 1)) ? 32'h0 : tb_cnt_ff + 32'h1;
    end
  end

  // Energy step with floor division and kept remainder
  logic signed [47:0] frac_ff;
  logic signed [47:0] sum;
  logic [47:0]        mag, dq, nxt_frac;
  logic               neg;

  always_comb begin
    sum = frac_ff + pwr_ff;
    neg = sum < 0;
    mag = neg ? 48'(-sum) : 48'(sum);
    dq  = ism_udiv(mag, `ISM_MILLI);
    if (neg && (dq * `ISM_MILLI != mag)) dq = dq + 48'h1;
    nxt_frac = neg ? 48'(dq * `ISM_MILLI - mag) : 48'(mag - dq * `ISM_MILLI);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      energy_ff <= '0;
      etime_ff  <= '0;
      frac_ff   <= '0;
    end else if (tick_ff) begin
      etime_ff <= etime_ff + 48'h1;
      if (!neg) begin
        energy_ff <= energy_ff + dq;
        frac_ff   <= $signed(nxt_frac);
      end else if (energy_ff < dq) begin
        energy_ff <= '0;
        frac_ff   <= '0;
      end else begin
        energy_ff <= energy_ff - dq;
        frac_ff   <= $signed(nxt_frac);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_REV_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
    go && !hold_ff.wr && hold_ff.code == `ISM_CMD_REV |=> rsp_word_ff == {8'h00, REV_CODE})
    else $error("revision code read wrong");
  AST_IDENT_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
    go && !hold_ff.wr && hold_ff.code == `ISM_CMD_IDENT |=> rsp_word_ff == IDENT_WORD)
    else $error("identity word read wrong");
  AST_LOT_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    nvm_bulk_done |=> lot_ff[0] == $past(nvm_lot[7:0]))
    else $error("lot code not loaded");
  AST_INFO_REFRESH: assert property (@(posedge clk) disable iff (sys_rst)
    nvm_bulk_done |=> info_ff[`ISM_INFO_ECC_BIT] == $past(nvm_ecc_ok))
    else $error("info word not refreshed");
  AST_INFO_RSVD: assert property (@(posedge clk) disable iff (sys_rst)
    (info_ff & ~(16'h0001 << `ISM_INFO_ECC_BIT)) == 16'h0000)
    else $error("info reserved bits set");
  AST_GSCRATCH_WR: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go && hold_ff.code == `ISM_CMD_GSCRATCH |=> glob_ff == $past(hold_ff.wdata))
    else $error("global scratch not written");
  AST_PSCRATCH_ISO: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go && hold_ff.code == `ISM_CMD_PSCRATCH && pg != 2'h0 |=> $stable(pscr_ff[0]))
    else $error("other page scratch disturbed");
  AST_MAKER_B_WR: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go && hold_ff.code == `ISM_CMD_MAKER_B && pg == 2'h2
    |=> maker_b_ff[2] == $past(hold_ff.wdata))
    else $error("paged reserved word not written");
  AST_RANGE_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go && hold_ff.code == `ISM_CMD_RANGE && hold_ff.wdata[1:0] == 2'h3
    |=> $stable(sense_range_ff))
    else $error("unused range value applied");
  AST_PWR_SIGN: assert property (@(posedge clk) disable iff (sys_rst)
    pwr_go_ff && cur_ff < 0 |=> pwr_ff <= 0)
    else $error("power sign wrong");
  AST_TIME_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    tick_ff |=> etime_ff == $past(etime_ff) + 48'h1)
    else $error("elapsed time not stepped");
  AST_ENERGY_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
    tick_ff && energy_ff == 48'h0 && pwr_ff < 0 && frac_ff == 0 |=> energy_ff == 48'h0)
    else $error("energy underflowed");
  AST_FRAC_BOUND: assert property (@(posedge clk) disable iff (sys_rst)
    frac_ff >= 0 && frac_ff < $signed(`ISM_MILLI))
    else $error("energy remainder out of bounds");
  AST_LINK_ANSWER: assert property (@(posedge lnk_clk) disable iff (sys_rst)
    accept |-> ##[3:30] lnk_rsp_valid_ff)
    else $error("link answer missing");

  COV_SCRATCH_WR: cover property (@(posedge clk) disable iff (sys_rst)
    wr_go && hold_ff.code == `ISM_CMD_PSCRATCH);
  COV_NEG_POWER: cover property (@(posedge clk) disable iff (sys_rst)
    tick_ff && pwr_ff < 0 && energy_ff != 48'h0);
  COV_EIN_READ: cover property (@(posedge clk) disable iff (sys_rst)
    go && !hold_ff.wr && ein_hit);

endmodule
`default_nettype wire

// [ism_host_model.sv]
// Host side model of the management link: one request at a time.
// Assumes the block's link ports on lnk_clk and a bench calling xfer.
`timescale 1ns/1ps
`default_nettype none

module ism_host_model
  import ism_pkg::*;
(
  input  wire logic        lnk_clk,
  output logic             lnk_req_valid,
  output ism_req_type      lnk_req,
  input  wire logic        lnk_busy_ff,
  input  wire logic        lnk_rsp_valid_ff,
  input  wire logic [15:0] lnk_rsp_data_ff
);
  // Idle link
  initial begin
    lnk_req_valid = 1'b0;
    lnk_req       = '0;
  end

  // Raise request, drop it after the taking edge, wait for the answer
  task automatic xfer(input ism_req_type req, output logic [15:0] rdata, output logic ok);
    int n;
    ok    = 1'b0;
    rdata = 16'h0000;
    @(posedge lnk_clk);
    lnk_req_valid <= 1'b1;
    lnk_req       <= req;
    for (n = 0; n < 40; n++) begin
      @(posedge lnk_clk);
      if (lnk_busy_ff === 1'b0) break;
    end
    lnk_req_valid <= 1'b0;
    lnk_req       <= ~req; // Stale fields do not linger
    for (n = 0; n < 40; n++) begin
      @(posedge lnk_clk);
      if (lnk_rsp_valid_ff === 1'b1) begin
        rdata = lnk_rsp_data_ff;
        ok    = 1'b1;
        break;
      end
    end
  endtask
endmodule

`default_nettype wire

// [ism_meter_regs_tb.sv]
// Self-checking bench for the identification, scratch and energy block.
// Assumes the package, constants header and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ism_defines.svh"

module ism_meter_regs_tb
  import ism_pkg::*;
;
  logic          clk;
  logic          sys_rst;
  logic          lnk_clk;
  logic          lnk_req_valid;
  ism_req_type   lnk_req;
  logic          lnk_busy_ff;
  logic          lnk_rsp_valid_ff;
  logic [15:0]   lnk_rsp_data_ff;
  logic          adc_valid;
  ism_adc_type   adc_sample;
  logic          nvm_bulk_done;
  logic          nvm_ecc_ok;
  logic [31:0]   nvm_lot;
  ism_range_type sense_range_ff;
  int            num_errors;
  int            n_compared;
  logic [15:0]   e1, e2, t1, t2, d;
  logic [42:0]   rows [28];

  ////////////////////////////////////////////////////////////////////
  // Clocks: 50 ns system, 30 ns link with unrelated phase
  initial clk = 1'b0;
  always #25 clk = ~clk;
  initial begin
    lnk_clk = 1'b0;
    #4;
    forever #15 lnk_clk = ~lnk_clk;
  end

  ism_meter_regs #(.TB_CYCLES(20)) i_ism_meter_regs (
    .clk(clk), .sys_rst(sys_rst), .lnk_clk(lnk_clk), .lnk_req_valid(lnk_req_valid),
    .lnk_req(lnk_req), .lnk_busy_ff(lnk_busy_ff), .lnk_rsp_valid_ff(lnk_rsp_valid_ff),
    .lnk_rsp_data_ff(lnk_rsp_data_ff), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .nvm_bulk_done(nvm_bulk_done), .nvm_ecc_ok(nvm_ecc_ok), .nvm_lot(nvm_lot),
    .sense_range_ff(sense_range_ff));

  ism_host_model i_ism_host_model (
    .lnk_clk(lnk_clk), .lnk_req_valid(lnk_req_valid), .lnk_req(lnk_req),
    .lnk_busy_ff(lnk_busy_ff), .lnk_rsp_valid_ff(lnk_rsp_valid_ff),
    .lnk_rsp_data_ff(lnk_rsp_data_ff));

  ////////////////////////////////////////////////////////////////////
  // Compare, transfer and stimulus tasks
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input ism_range_type got, input ism_range_type exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic access(input ism_req_type rq, output logic [15:0] rd);
    logic ok;
    i_ism_host_model.xfer(rq, rd, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      results();
    end
  endtask

  task automatic rd(input logic [7:0] code, input logic [1:0] pg, input logic [15:0] exp);
    logic [15:0] v;
    access({1'b0, code, pg, 16'h0000}, v);
    chk_word(v, exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [1:0] pg, input logic [15:0] wd);
    logic [15:0] v;
    access({1'b1, code, pg, wd}, v);
  endtask

  // One converter sample, then let power settle
  task automatic adc(input logic [15:0] mv, input logic [17:0] uv, input logic [7:0] tc);
    @(posedge clk);
    adc_valid  <= 1'b1;
    adc_sample <= {mv, uv, tc};
    @(posedge clk);
    adc_valid  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Ordinary cases: {wr, code, page, wdata, expected answer}
  initial begin
    rows = '{
      {1'b0, 8'h98, 2'h0, 16'h0000, 16'h005A}, {1'b1, 8'h98, 2'h0, 16'hFFFF, 16'h0000},
      {1'b0, 8'h98, 2'h0, 16'h0000, 16'h005A}, {1'b1, 8'hE7, 2'h0, 16'h1234, 16'h0000},
      {1'b0, 8'hE7, 2'h0, 16'h0000, 16'hA5C3}, {1'b0, 8'hC2, 2'h2, 16'h0000, 16'h0033},
      {1'b0, 8'hB6, 2'h0, 16'h0000, 16'h0020}, {1'b0, 8'hB3, 2'h0, 16'h0000, 16'h0000},
      {1'b0, 8'hB4, 2'h0, 16'h0000, 16'h0000}, {1'b1, 8'hB3, 2'h0, 16'h1111, 16'h0000},
      {1'b1, 8'hB3, 2'h3, 16'h2222, 16'h0000}, {1'b1, 8'hB4, 2'h2, 16'h3333, 16'h0000},
      {1'b0, 8'hB3, 2'h0, 16'h0000, 16'h1111}, {1'b0, 8'hB3, 2'h3, 16'h0000, 16'h2222},
      {1'b0, 8'hB3, 2'h1, 16'h0000, 16'h0000}, {1'b0, 8'hB4, 2'h0, 16'h0000, 16'h3333},
      {1'b1, 8'hB1, 2'h3, 16'hABCD, 16'h0000}, {1'b0, 8'hB1, 2'h0, 16'h0000, 16'h0000},
      {1'b1, 8'hB0, 2'h1, 16'h1234, 16'h0000}, {1'b0, 8'hB0, 2'h2, 16'h0000, 16'h1234},
      {1'b1, 8'hB5, 2'h1, 16'h6666, 16'h0000}, {1'b0, 8'hB5, 2'h1, 16'h0000, 16'h6666},
      {1'b1, 8'hBC, 2'h2, 16'h7777, 16'h0000}, {1'b0, 8'hBC, 2'h0, 16'h0000, 16'h0000},
      {1'b0, 8'hBC, 2'h2, 16'h0000, 16'h7777}, {1'b0, 8'hB1, 2'h3, 16'h0000, 16'hABCD},
      {1'b1, 8'hB2, 2'h0, 16'h5555, 16'h0000}, {1'b0, 8'hB2, 2'h1, 16'h0000, 16'h5555}};
    num_errors    = 0;
    n_compared    = 0;
    sys_rst       = 1'b1;
    adc_valid     = 1'b0;
    adc_sample    = '0;
    nvm_bulk_done = 1'b0;
    nvm_ecc_ok    = 1'b1;
    nvm_lot       = 32'h44332211;
    repeat (5) @(posedge clk);
    chk_range(sense_range_ff, ISM_RNG_HIGH);
    chk_word({14'h0000, lnk_busy_ff, lnk_rsp_valid_ff}, 16'h0000);
    sys_rst <= 1'b0;
    repeat (4) @(posedge lnk_clk);
    foreach (rows[i]) begin
      access(rows[i][42:16], d);
      chk_word(d, rows[i][15:0]);
    end
    $display("Table done");
    // Range field: every code, then the unused value is ignored
    for (int r = 0; r < 3; r++) begin
      wr(8'hDA, 2'h0, 16'(r));
      chk_range(sense_range_ff, ism_range_type'(r));
    end
    wr(8'hDA, 2'h0, 16'h0003);
    chk_range(sense_range_ff, ISM_RNG_LOW);
    $display("Range done");
    // Information and lot refresh on bulk read and restore
    @(posedge clk);
    nvm_ecc_ok    <= 1'b0;
    nvm_lot       <= 32'h88776655;
    nvm_bulk_done <= 1'b1;
    @(posedge clk);
    nvm_bulk_done <= 1'b0;
    rd(8'hB6, 2'h0, 16'h0000);
    rd(8'hC2, 2'h1, 16'h0066);
    @(posedge clk);
    nvm_ecc_ok <= 1'b1;
    wr(8'h16, 2'h0, 16'h0000);
    rd(8'hB6, 2'h0, 16'h0020);
    $display("Refresh done");
    // Power, current and energy accumulation at 1500 mW
    adc(16'h05DC, 18'sh003E8, 8'sh19);
    rd(8'hDC, 2'h0, 16'h03E8);
    rd(8'hDB, 2'h0, 16'h05DC);
    repeat (400) @(posedge clk);
    access({1'b0, 8'hD0, 2'h0, 16'h0000}, e1);
    access({1'b0, 8'hD3, 2'h0, 16'h0000}, t1);
    repeat (2000) @(posedge clk);
    access({1'b0, 8'hD0, 2'h0, 16'h0000}, e2);
    access({1'b0, 8'hD3, 2'h0, 16'h0000}, t2);
    chk_word(16'(2 * (e2 - e1) + 1 >= 3 * (t2 - t1)), 16'h0001);
    chk_word(16'(2 * (e2 - e1) <= 3 * (t2 - t1) + 1), 16'h0001);
    chk_word(16'(t2 - t1 > 16'h005A), 16'h0001);
    // Negative power drains energy down to zero and holds it there
    adc(16'h03E8, -18'sh003E8, 8'sh19);
    rd(8'hDB, 2'h0, 16'hFC18);
    repeat (6000) @(posedge clk);
    rd(8'hD0, 2'h0, 16'h0000);
    rd(8'hD1, 2'h0, 16'h0000);
    rd(8'hD2, 2'h0, 16'h0000);
    rd(8'hD4, 2'h0, 16'h0000);
    rd(8'hD5, 2'h0, 16'h0000);
    $display("Energy done");
    // Gain in milliohms and temperature compensation
    wr(8'hD8, 2'h0, 16'h0002);
    wr(8'hD9, 2'h0, 16'h2710);
    adc(16'h03E8, 18'sh00528, 8'sh23);
    rd(8'hDC, 2'h0, 16'h0258);
    wr(8'hD9, 2'h0, 16'h0000);
    adc(16'h03E8, 18'sh00528, 8'sh23);
    rd(8'hDC, 2'h0, 16'h0294);
    $display("Gain done");
    // Mid-run reset returns the words to their reset values
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    chk_range(sense_range_ff, ISM_RNG_HIGH);
    chk_word({14'h0000, lnk_busy_ff, lnk_rsp_valid_ff}, 16'h0000);
    chk_word(lnk_rsp_data_ff, 16'h0000);
    sys_rst <= 1'b0;
    repeat (4) @(posedge lnk_clk);
    rd(8'hB4, 2'h0, 16'h0000);
    rd(8'hB3, 2'h0, 16'h0000);
    rd(8'hD8, 2'h0, 16'h0001);
    $display("Reset done");
    results();
  end
endmodule

`default_nettype wire
